// ### sim/hdtx_oh_model.sv
// Purpose: Overhead path model, strobes bits and records the line
// Assumes: One bit per strobe, line read one edge after its strobe
// Notes: Slow pacing strobes every third cycle
`timescale 1ns/1ps
module hdtx_oh_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Pacing
	input wire logic slow,
	// Link
	input wire logic tx_line,
	output logic tx_bit_en
);
	logic [1:0] cnt;
	logic pend;
	bit cap[$];

	// ----------------------------------------------------------------
	// Strobe and capture
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt <= 2'h0;
			pend <= 1'b0;
			tx_bit_en <= 1'b0;
		end
		else
		begin
			cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
			tx_bit_en <= !slow || cnt == 2'h2;
			if (pend)
				cap.push_back(tx_line);
			pend <= tx_bit_en;
		end
	end
endmodule

// ### sim/tb_top.sv
// Purpose: Register and line checks of the transmit controller
// Assumes: Zero wait AHB-Lite slave, overhead path model
// Notes: Expected line streams are built from the framing rules
`timescale 1ns/1ps
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic hreadyout, hresp, tx_bit_en, tx_line;
	logic slow = 1'b0;
	logic ce = 1'b1;
	logic lv;
	int n_mismatch = 0;
	int tests_run = 0;
	int ones;
	bit q[$];
	logic [15:0] modes [6] = '{16'h0000, 16'h0020, 16'h0002, 16'h000a,
		16'h0004, 16'h0010};

	always #5 hclk = ~hclk;

	hdtx_top i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.tx_bit_en(tx_bit_en), .tx_line(tx_line));

	hdtx_oh_model i_oh (.hclk(hclk), .hresetn(hresetn), .slow(slow),
		.tx_line(tx_line), .tx_bit_en(tx_bit_en));

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic bus(input logic [7:0] idx, input logic wr_en,
		input logic [15:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr_en;
		haddr <= {22'h0, idx, 2'h0};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0, wd};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		chk_reg("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
		bus(idx, 1'b1, wd);
	endtask

	task automatic chk_reg(string n, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_line(string n, logic e, logic g);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [15:0] e,
		input logic [15:0] m = 16'hffff);
		bus(idx, 1'b0, 16'h0);
		chk_reg($sformatf("reg %h", idx), {16'h0, e}, rd & {16'h0, m});
	endtask

	// ----------------------------------------------------------------
	// Expected line stream
	// ----------------------------------------------------------------
	task automatic add(input logic [7:0] b, input bit st, input bit msb);
		bit v;
		for (int i = 0; i < 8; i++)
		begin
			v = msb ? b[7 - i] : b[i];
			q.push_back(v);
			ones = (st && v) ? ones + 1 : 0;
			if (ones == 5)
			begin
				q.push_back(1'b0);
				ones = 0;
			end
		end
	endtask

	function automatic logic [15:0] crc8(logic [15:0] c, logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ b[i]) ? (c >> 1) ^ hdtx_pkg::CRC_POLY : c >> 1;
		return c;
	endfunction

	task automatic build(input logic [15:0] c, input logic [7:0] b0,
		input logic [7:0] b1);
		logic [15:0] crc;
		q.delete();
		ones = 0;
		add(hdtx_pkg::FLAG_BYTE, 1'b0, 1'b0);
		add(b0, 1'b1, c[3]);
		add(b1, 1'b1, c[3]);
		crc = crc8(crc8(hdtx_pkg::CRC_INIT, b0), b1);
		if (!c[5])
			crc = ~crc;
		if (!c[1])
		begin
			add(crc[7:0], 1'b1, 1'b0);
			add(crc[15:8], 1'b1, 1'b0);
		end
		add(hdtx_pkg::FLAG_BYTE, 1'b0, 1'b0);
	endtask

	function automatic logic found(input logic inv);
		logic m;
		for (int s = 0; s + q.size() <= i_oh.cap.size(); s++)
		begin
			m = 1'b1;
			for (int k = 0; k < q.size(); k++)
				if ((i_oh.cap[s + k] ^ inv) != q[k])
					m = 1'b0;
			if (m)
				return 1'b1;
		end
		return 1'b0;
	endfunction

	function automatic int maxrun(input logic inv);
		int r;
		int best;
		r = 0;
		best = 0;
		foreach (i_oh.cap[i])
		begin
			r = (i_oh.cap[i] ^ inv) ? r + 1 : 0;
			best = (r > best) ? r : best;
		end
		return best;
	endfunction

	task automatic send_pkt;
		wr(hdtx_pkg::IDX_DATA, 16'hf800);
		wr(hdtx_pkg::IDX_DATA, 16'h4101);
	endtask

	task automatic stop_test;
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		#200000;
		n_mismatch++;
		stop_test();
	end

	initial
	begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(hdtx_pkg::IDX_CTRL, 16'h0800);
		rchk(hdtx_pkg::IDX_STAT, 16'h0202);
		rchk(hdtx_pkg::IDX_DATA, 16'h0000);
		rchk(hdtx_pkg::IDX_IEN, 16'h0000);
		rchk(8'haa, 16'h0000);
		wr(hdtx_pkg::IDX_IEN, 16'hffff);
		rchk(hdtx_pkg::IDX_IEN, 16'h003b);
		wr(hdtx_pkg::IDX_CTRL, 16'h0140);
		rchk(hdtx_pkg::IDX_STAT, 16'h0203);
		repeat (7) wr(hdtx_pkg::IDX_DATA, 16'h5500);
		rchk(hdtx_pkg::IDX_STAT, 16'h0101);
		wr(hdtx_pkg::IDX_DATA, 16'h5500);
		rchk(hdtx_pkg::IDX_STAT, 16'h0100);
		repeat (9) wr(hdtx_pkg::IDX_DATA, 16'h5500);
		rchk(hdtx_pkg::IDX_STAT, 16'h0004);
		rchk(hdtx_pkg::IDX_LATCH, 16'h0020, 16'h0020);
		wr(hdtx_pkg::IDX_CTRL, 16'h0141);
		wr(hdtx_pkg::IDX_DATA, 16'h5501);
		rchk(hdtx_pkg::IDX_STAT, 16'h0203);
		wr(hdtx_pkg::IDX_LATCH, 16'h003b);
		wr(hdtx_pkg::IDX_CTRL, 16'h0140);
		wr(hdtx_pkg::IDX_DATA, 16'h5501);
		rchk(hdtx_pkg::IDX_LATCH, 16'h0003, 16'h0003);
		rchk(hdtx_pkg::IDX_STAT, 16'h0203);
		repeat (10) @(posedge hclk);
		wr(hdtx_pkg::IDX_DATA, 16'h5500);
		rchk(hdtx_pkg::IDX_STAT, 16'h0101);
		wr(hdtx_pkg::IDX_CTRL, 16'h0141);
		wr(hdtx_pkg::IDX_CTRL, 16'h0000);
		repeat (10) @(posedge hclk);
		foreach (modes[m])
		begin
			slow <= m[0];
			lv = modes[m][2];
			wr(hdtx_pkg::IDX_CTRL, modes[m]);
			repeat (20) @(posedge hclk);
			i_oh.cap.delete();
			send_pkt();
			repeat (400) @(posedge hclk);
			build(modes[m], 8'hf8, 8'h41);
			chk_line("packet", 1'b1, found(lv));
			chk_line("fill", modes[m][4], maxrun(lv) > 15);
		end
		slow <= 1'b0;
		wr(hdtx_pkg::IDX_CTRL, 16'h0040);
		i_oh.cap.delete();
		send_pkt();
		repeat (300) @(posedge hclk);
		build(16'h0000, 8'hf8, 8'h41);
		chk_line("inhibit", 1'b0, found(1'b0));
		wr(hdtx_pkg::IDX_CTRL, 16'h0000);
		repeat (300) @(posedge hclk);
		chk_line("resume", 1'b1, found(1'b0));
		ce <= 1'b0;
		@(posedge hclk);
		lv = tx_line;
		repeat (8)
		begin
			@(posedge hclk);
			chk_line("freeze", lv, tx_line);
		end
		ce <= 1'b1;
		wr(hdtx_pkg::IDX_DATA, 16'h4100);
		repeat (300) @(posedge hclk);
		rchk(hdtx_pkg::IDX_LATCH, 16'h0018, 16'h0018);
		stop_test();
	end
endmodule

// ### verilog/hdtx_pkg.sv
// Purpose: Constants and types for the HDLC transmit controller
// Assumes: AHB-Lite register access, 16-bit registers in word slots
// Notes: Register indices times four give the byte addresses
package hdtx_pkg;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CTRL = 8'ha0;
	localparam logic [7:0] IDX_DATA = 8'ha2;
	localparam logic [7:0] IDX_STAT = 8'ha4;
	localparam logic [7:0] IDX_LATCH = 8'ha6;
	localparam logic [7:0] IDX_IEN = 8'ha8;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] CTRL_RESET = 16'h0800;
	localparam logic [15:0] CTRL_MASK = 16'h1f7f;
	localparam logic [15:0] EVT_MASK = 16'h003b;
	localparam logic [4:0] LEVEL_RESET = 5'h08;
	localparam int DATA_BYTE_LSB = 8;
	localparam int DATA_LAST_BIT = 0;
	localparam int STAT_FILL_LSB = 8;
	localparam int STAT_FULL = 2;
	localparam int STAT_EMPTY = 1;
	localparam int STAT_AVAIL = 0;
	localparam int LAT_OVF = 5;
	localparam int LAT_UNF = 4;
	localparam int LAT_PEND = 3;
	localparam int LAT_EMPTY = 1;
	localparam int LAT_AVAIL = 0;

	typedef struct packed {
		logic [2:0] rsv_hi;
		logic [4:0] level;
		logic rsv7;
		logic inhibit;
		logic force_err;
		logic fill_ones;
		logic msb_first;
		logic invert;
		logic fcs_off;
		logic flush;
	} hdtx_ctrl_s;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} hdtx_entry_s;

	// ----------------------------------------------------------------
	// Framing and timing
	// ----------------------------------------------------------------
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] FLAG_BYTE = 8'h7e;
	localparam logic [7:0] ONES_BYTE = 8'hff;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [2:0] STUFF_LIMIT = 3'h5;
	localparam int CLK_NS = 10;
	localparam int POWERUP_NS = 40;
	localparam int POWERUP_CYC = (POWERUP_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OPEN = 3'b001,
		ST_DATA = 3'b010,
		ST_FCS_LO = 3'b011,
		ST_FCS_HI = 3'b100,
		ST_CLOSE = 3'b101
	} hdtx_state_e;

endpackage

// ### verilog/hdtx_top.sv
// Purpose: HDLC transmit packet processor with its transmit FIFO
// Assumes: One clock, bit strobe from the overhead insertion path
`timescale 1ns/1ps

// --------------------------------------------------------------------
// Synchronous FIFO
// --------------------------------------------------------------------
module hdtx_fifo #(
	parameter int W = 9,
	parameter int D = 16
) (
	// Clock and control
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic clear,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	// Free entries
	output logic [$clog2(D):0] free
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_reg [D];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;

	assign in_ready = (cnt_reg != D[AW:0]) && !clear;
	assign out_valid = (cnt_reg != '0) && !clear;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rp_reg];
	assign free = D[AW:0] - cnt_reg;

	always_ff @(posedge clk)
	begin
		if (ce && push)
		begin
			mem_reg[wp_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end
		else if (ce)
		begin
			if (clear)
			begin
				wp_reg <= '0;
				rp_reg <= '0;
				cnt_reg <= '0;
			end
			else
			begin
				if (push)
					wp_reg <= wp_reg + 1'b1;
				if (pop)
					rp_reg <= rp_reg + 1'b1;
				if (push && !pop)
					cnt_reg <= cnt_reg + 1'b1;
				else if (pop && !push)
					cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule

// --------------------------------------------------------------------
// Transmit controller top
// --------------------------------------------------------------------
module hdtx_top (
	// Clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Overhead path
	input wire logic tx_bit_en,
	output logic tx_line
);
	localparam int FW = $bits(hdtx_pkg::hdtx_entry_s);

	hdtx_pkg::hdtx_ctrl_s ctrl_reg;
	logic [15:0] lat_reg;
	logic [15:0] ien_reg;
	logic wr_pend_reg;
	logic [7:0] idx_reg;
	logic [31:0] hrdata_reg;
	hdtx_pkg::hdtx_state_e st_reg;
	hdtx_pkg::hdtx_state_e st_next;
	logic [7:0] shift_reg;
	logic [7:0] load_next;
	logic [2:0] bit_cnt_reg;
	logic [2:0] ones_reg;
	logic [15:0] crc_reg;
	logic [15:0] crc_next;
	logic [15:0] fcs_val;
	logic cur_last_reg;
	logic line_reg;
	logic [2:0] pwr_cnt_reg;
	logic flush_d_reg;
	logic empty_d_reg;
	logic avail_d_reg;
	logic ctl_written_reg;
	logic addr_ok;
	logic data_wr;
	logic push_req;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic pop;
	hdtx_pkg::hdtx_entry_s fifo_out;
	hdtx_pkg::hdtx_entry_s fifo_in;
	logic [4:0] free;
	logic avail;
	logic [8:0] need;
	logic stuff_on;
	logic do_stuff;
	logic raw_bit;
	logic byte_done;
	logic underflow;
	logic [15:0] lat_set;
	logic [15:0] stat_val;
	logic [15:0] rd_val;
	logic [7:0] fill_byte;

	function automatic logic [7:0] order8(input logic [7:0] b,
		input logic msb);
		order8 = msb ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]}
			: b;
	endfunction

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign addr_ok = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign data_wr = wr_pend_reg && (idx_reg == hdtx_pkg::IDX_DATA);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			idx_reg <= '0;
			hrdata_reg <= '0;
		end
		else if (ce)
		begin
			wr_pend_reg <= addr_ok && hwrite;
			idx_reg <= haddr[9:2];
			if (addr_ok && !hwrite)
				hrdata_reg <= {16'h0000, rd_val};
		end
	end

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	assign need = {1'b0, ctrl_reg.level, 3'b000} + 9'h001;
	assign avail = {4'h0, free} >= need;
	always_comb
	begin
		stat_val = '0;
		stat_val[hdtx_pkg::STAT_FILL_LSB +: 6] = {4'h0, free[4:3]};
		stat_val[hdtx_pkg::STAT_FULL] = !fifo_in_ready && !ctrl_reg.flush;
		stat_val[hdtx_pkg::STAT_EMPTY] = !fifo_out_valid;
		stat_val[hdtx_pkg::STAT_AVAIL] = avail;
	end
	always_comb
	begin
		case (haddr[9:2])
			hdtx_pkg::IDX_CTRL: rd_val = ctrl_reg;
			hdtx_pkg::IDX_DATA: rd_val = 16'h0000;
			hdtx_pkg::IDX_STAT: rd_val = stat_val;
			hdtx_pkg::IDX_LATCH: rd_val = lat_reg;
			hdtx_pkg::IDX_IEN: rd_val = ien_reg;
			default: rd_val = 16'h0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg <= hdtx_pkg::CTRL_RESET;
			ien_reg <= '0;
			ctl_written_reg <= 1'b0;
		end
		else if (ce && wr_pend_reg)
		begin
			if (idx_reg == hdtx_pkg::IDX_CTRL)
			begin
				ctrl_reg <= hwdata[15:0] & hdtx_pkg::CTRL_MASK;
				ctl_written_reg <= 1'b1;
			end
			if (idx_reg == hdtx_pkg::IDX_IEN)
				ien_reg <= hwdata[15:0] & hdtx_pkg::EVT_MASK;
		end
	end

	// Latched events, set wins over write-one clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lat_reg <= '0;
			flush_d_reg <= 1'b0;
			empty_d_reg <= 1'b1;
			avail_d_reg <= 1'b0;
		end
		else if (ce)
		begin
			flush_d_reg <= ctrl_reg.flush;
			empty_d_reg <= !fifo_out_valid;
			avail_d_reg <= avail;
			if (wr_pend_reg && idx_reg == hdtx_pkg::IDX_LATCH)
				lat_reg <= (lat_reg & ~hwdata[15:0]) | lat_set;
			else
				lat_reg <= lat_reg | lat_set;
		end
	end

	always_comb
	begin
		lat_set = '0;
		lat_set[hdtx_pkg::LAT_OVF] = push_req && !fifo_in_ready;
		lat_set[hdtx_pkg::LAT_UNF] = underflow;
		lat_set[hdtx_pkg::LAT_PEND] = pop && fifo_out.last;
		lat_set[hdtx_pkg::LAT_EMPTY] = (!fifo_out_valid && !empty_d_reg)
			|| (flush_d_reg && !ctrl_reg.flush);
		lat_set[hdtx_pkg::LAT_AVAIL] = (avail && !avail_d_reg)
			|| (flush_d_reg && !ctrl_reg.flush);
	end

	// ----------------------------------------------------------------
	// FIFO fill and power-up hold-off
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pwr_cnt_reg <= '0;
		else if (ce)
		begin
			if (ctrl_reg.flush)
				pwr_cnt_reg <= 3'(hdtx_pkg::POWERUP_CYC);
			else if (pwr_cnt_reg != '0)
				pwr_cnt_reg <= pwr_cnt_reg - 1'b1;
		end
	end

	// Data port writes are dropped while flushing or powering up
	assign push_req = data_wr && !ctrl_reg.flush
		&& (pwr_cnt_reg == '0);
	assign fifo_in.data = hwdata[hdtx_pkg::DATA_BYTE_LSB +: 8];
	assign fifo_in.last = hwdata[hdtx_pkg::DATA_LAST_BIT];

	hdtx_fifo #(
		.W(FW),
		.D(hdtx_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(hclk),
		.rstn(hresetn),
		.ce(ce),
		.clear(ctrl_reg.flush),
		.in_valid(push_req),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out),
		.free(free)
	);

	// ----------------------------------------------------------------
	// Bit engine and framing sequence
	// ----------------------------------------------------------------
	assign fill_byte = ctrl_reg.fill_ones ? hdtx_pkg::ONES_BYTE
		: hdtx_pkg::FLAG_BYTE;
	assign stuff_on = (st_reg == hdtx_pkg::ST_DATA)
		|| (st_reg == hdtx_pkg::ST_FCS_LO) || (st_reg == hdtx_pkg::ST_FCS_HI);
	// Closing flag waits for the zero owed after five trailing ones
	assign do_stuff = (ones_reg == hdtx_pkg::STUFF_LIMIT) && (stuff_on
		|| (st_reg == hdtx_pkg::ST_CLOSE && bit_cnt_reg == 3'h0));
	assign raw_bit = do_stuff ? 1'b0 : shift_reg[0];
	assign byte_done = tx_bit_en && !do_stuff && (bit_cnt_reg == 3'h7);
	assign fcs_val = ctrl_reg.force_err ? crc_next : ~crc_next;

	always_comb
	begin
		crc_next = crc_reg;
		if (tx_bit_en && !do_stuff && st_reg == hdtx_pkg::ST_DATA)
			crc_next = (crc_reg >> 1)
				^ ((shift_reg[0] ^ crc_reg[0]) ? hdtx_pkg::CRC_POLY : 16'h0000);
	end

	always_comb
	begin
		st_next = st_reg;
		load_next = fill_byte;
		pop = 1'b0;
		underflow = 1'b0;
		case (st_reg)
			hdtx_pkg::ST_IDLE, hdtx_pkg::ST_CLOSE:
			begin
				st_next = hdtx_pkg::ST_IDLE;
				if (fifo_out_valid && !ctrl_reg.inhibit)
				begin
					st_next = hdtx_pkg::ST_OPEN;
					load_next = hdtx_pkg::FLAG_BYTE;
				end
			end
			hdtx_pkg::ST_OPEN, hdtx_pkg::ST_DATA:
			begin
				if (st_reg == hdtx_pkg::ST_DATA && cur_last_reg)
				begin
					st_next = ctrl_reg.fcs_off ? hdtx_pkg::ST_CLOSE
						: hdtx_pkg::ST_FCS_LO;
					load_next = ctrl_reg.fcs_off ? hdtx_pkg::FLAG_BYTE
						: fcs_val[7:0];
				end
				else if (fifo_out_valid)
				begin
					st_next = hdtx_pkg::ST_DATA;
					pop = byte_done;
					load_next = order8(fifo_out.data,
						ctrl_reg.msb_first);
				end
				else
				begin
					st_next = hdtx_pkg::ST_CLOSE;
					load_next = hdtx_pkg::FLAG_BYTE;
					underflow = byte_done;
				end
			end
			hdtx_pkg::ST_FCS_LO:
			begin
				st_next = hdtx_pkg::ST_FCS_HI;
				load_next = fcs_val[15:8];
			end
			hdtx_pkg::ST_FCS_HI:
			begin
				st_next = hdtx_pkg::ST_CLOSE;
				load_next = hdtx_pkg::FLAG_BYTE;
			end
			default:
			begin
				st_next = hdtx_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_reg <= hdtx_pkg::ST_IDLE;
			shift_reg <= hdtx_pkg::FLAG_BYTE;
			bit_cnt_reg <= '0;
			ones_reg <= '0;
			crc_reg <= hdtx_pkg::CRC_INIT;
			cur_last_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (ctrl_reg.flush)
			begin
				st_reg <= hdtx_pkg::ST_IDLE;
				shift_reg <= fill_byte;
				bit_cnt_reg <= '0;
				ones_reg <= '0;
			end
			else if (tx_bit_en)
			begin
				ones_reg <= (do_stuff || !shift_reg[0]) ? 3'h0
					: ones_reg + 1'b1;
				crc_reg <= (st_next == hdtx_pkg::ST_OPEN && byte_done)
					? hdtx_pkg::CRC_INIT : crc_next;
				if (!do_stuff)
				begin
					bit_cnt_reg <= bit_cnt_reg + 1'b1;
					shift_reg <= {1'b0, shift_reg[7:1]};
				end
				if (byte_done)
				begin
					st_reg <= st_next;
					shift_reg <= load_next;
					if (pop)
						cur_last_reg <= fifo_out.last;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			line_reg <= 1'b1;
		else if (ce && tx_bit_en)
			line_reg <= raw_bit ^ ctrl_reg.invert;
	end
	assign tx_line = line_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_avail_level: assert property (avail |->
		({4'h0, free} > {1'b0, ctrl_reg.level, 3'b000}))
		else $error("available flag without enough free space");
	a_level_reset: assert property (!ctl_written_reg |->
		ctrl_reg.level == hdtx_pkg::LEVEL_RESET)
		else $error("level field lost reset value");
	a_inhibit_hold: assert property (ce && byte_done && ctrl_reg.inhibit
		&& st_reg == hdtx_pkg::ST_IDLE |=> st_reg == hdtx_pkg::ST_IDLE)
		else $error("packet started while inhibited");
	a_fcs_form: assert property (ce && byte_done && !ctrl_reg.flush
		&& st_next == hdtx_pkg::ST_FCS_LO |=>
		shift_reg == (ctrl_reg.force_err ? $past(crc_next[7:0])
		: ~$past(crc_next[7:0])))
		else $error("check sequence byte wrong");
	a_fill_flag: assert property (ce && byte_done && !ctrl_reg.flush
		&& !ctrl_reg.fill_ones && st_next == hdtx_pkg::ST_IDLE
		|=> shift_reg == hdtx_pkg::FLAG_BYTE)
		else $error("idle fill not a flag");
	a_no_fcs: assert property (ce && byte_done && !ctrl_reg.flush
		&& st_reg == hdtx_pkg::ST_DATA && cur_last_reg && ctrl_reg.fcs_off
		|=> st_reg == hdtx_pkg::ST_CLOSE)
		else $error("check sequence sent while disabled");
	a_flush_empty: assert property (ctrl_reg.flush |->
		!fifo_out_valid ##1 (!ce || bit_cnt_reg == 3'h0 || !ctrl_reg.flush))
		else $error("flush left data queued");
	a_powerup_drop: assert property ($fell(ctrl_reg.flush) |->
		!push_req [*2])
		else $error("write accepted during power-up");
	a_read_zero: assert property (ce && addr_ok && !hwrite
		&& haddr[9:2] == hdtx_pkg::IDX_DATA |=> hrdata == 32'h0)
		else $error("data port read not zero");
	a_stuff_limit: assert property (stuff_on |->
		ones_reg <= hdtx_pkg::STUFF_LIMIT)
		else $error("six ones inside a packet");

	c_packet_fcs: cover property (st_reg == hdtx_pkg::ST_FCS_HI
		##[1:200] st_reg == hdtx_pkg::ST_CLOSE);
	c_underflow: cover property (underflow);
	c_overflow: cover property (push_req && !fifo_in_ready);
	c_stuffed: cover property (tx_bit_en && do_stuff);
endmodule
